// ===== core/ram_block_pkg.sv
// package: shared constants, types and helpers of the dual-port block ram
package ram_block_pkg;

	localparam int TOTAL_BITS   = 4608;
	localparam int ROW_BITS     = 36;
	localparam int ROWS         = 128;
	localparam int ADDR_W       = 12;
	localparam int DATA_W       = 36;
	localparam int BMASK_W      = 4;
	localparam int TDP_MAX_BITS = 18;
	localparam int DIRECT_LINKS = 10;
	localparam int MIN_TAP_LEN  = 2;

	localparam logic [35:0] RDATA_RST = 36'h0_0000_0000;
	localparam logic [11:0] PTR_RST   = 12'h000;
	localparam logic [12:0] COUNT_RST = 13'h0000;
	localparam logic [6:0]  ROW_RST   = 7'h00;

	typedef enum logic [2:0] {
		MODE_TDP   = 3'b000,
		MODE_SDP   = 3'b001,
		MODE_SP    = 3'b010,
		MODE_FIFO  = 3'b011,
		MODE_ROM   = 3'b100,
		MODE_SHIFT = 3'b101
	} mode_t;

	typedef enum logic [3:0] {
		W1  = 4'b0000,
		W2  = 4'b0001,
		W4  = 4'b0010,
		W8  = 4'b0011,
		W16 = 4'b0100,
		W32 = 4'b0101,
		W9  = 4'b0110,
		W18 = 4'b0111,
		W36 = 4'b1000
	} width_t;

	// bit p of the two-bit fields belongs to port p (0 = a, 1 = b)
	typedef struct packed {
		mode_t       mode;
		width_t      width_a;
		width_t      width_b;
		logic [1:0]  out_reg;
		logic [1:0]  in_cross;
		logic [1:0]  out_cross;
		logic [7:0]  tap_len;
		logic [2:0]  tap_count;
	} cfg_t;

	typedef struct packed {
		logic              gate;
		logic              we;
		logic              clr;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [BMASK_W-1:0] bmask;
	} port_in_t;

	typedef struct packed {
		logic        en;
		logic [6:0]  row;
		logic [35:0] bwe;
		logic [35:0] wdata;
	} mem_req_t;

	function automatic logic [5:0] width_bits(input width_t w);
		case (w)
			W1:      width_bits = 6'h01;
			W2:      width_bits = 6'h02;
			W4:      width_bits = 6'h04;
			W8:      width_bits = 6'h08;
			W16:     width_bits = 6'h10;
			W32:     width_bits = 6'h20;
			W9:      width_bits = 6'h09;
			W18:     width_bits = 6'h12;
			W36:     width_bits = 6'h24;
			default: width_bits = 6'h01;
		endcase
	endfunction

	// log2 of words per 36-bit row
	function automatic logic [2:0] lane_shift(input width_t w);
		case (w)
			W1:      lane_shift = 3'h5;
			W2:      lane_shift = 3'h4;
			W4:      lane_shift = 3'h3;
			W8, W9:  lane_shift = 3'h2;
			W16, W18: lane_shift = 3'h1;
			default: lane_shift = 3'h0;
		endcase
	endfunction

	function automatic logic is_parity(input width_t w);
		is_parity = (w == W9) || (w == W18) || (w == W36);
	endfunction

	function automatic logic has_bytes(input width_t w);
		has_bytes = (w == W16) || (w == W18) || (w == W32) || (w == W36);
	endfunction

endpackage

// ===== core/ram_array.sv
// memory: two-port row array with per-bit write enables and registered read data
`timescale 1ns/1ps
module ram_array #(
	parameter int                     ROWS       = ram_block_pkg::ROWS,
	parameter int                     WIDTH      = ram_block_pkg::ROW_BITS,
	parameter int                     RAW        = $clog2(ROWS),
	parameter logic [ROWS*WIDTH-1:0]  INIT_IMAGE = '0
) (
	input  wire logic             clk,
	input  wire logic             a_en,
	input  wire logic [RAW-1:0]   a_row,
	input  wire logic [WIDTH-1:0] a_bwe,
	input  wire logic [WIDTH-1:0] a_wdata,
	output logic      [WIDTH-1:0] a_rdata_q,
	input  wire logic             b_en,
	input  wire logic [RAW-1:0]   b_row,
	input  wire logic [WIDTH-1:0] b_bwe,
	input  wire logic [WIDTH-1:0] b_wdata,
	output logic      [WIDTH-1:0] b_rdata_q
);

	typedef logic [WIDTH-1:0] row_arr_t [ROWS];

	// preset contents, given at declaration so only the write process drives mem
	function automatic row_arr_t unpack_image();
		row_arr_t img;
		for (int r = 0; r < ROWS; r++) begin
			img[r] = INIT_IMAGE[r*WIDTH +: WIDTH];
		end
		return img;
	endfunction

	row_arr_t         mem = unpack_image();
	logic [WIDTH-1:0] a_merged;
	logic [WIDTH-1:0] b_base;

	// unmasked bits keep their stored value
	assign a_merged = (mem[a_row] & ~a_bwe) | (a_wdata & a_bwe);
	// same-row writes from both ports merge, b wins on overlapping bits
	assign b_base   = (a_en && a_row == b_row) ? a_merged : mem[b_row];

	always_ff @(posedge clk) begin
		if (a_en) begin
			a_rdata_q  <= mem[a_row];
			mem[a_row] <= a_merged;
		end
		if (b_en) begin
			b_rdata_q  <= mem[b_row];
			mem[b_row] <= (b_base & ~b_bwe) | (b_wdata & b_bwe);
		end
	end

endmodule

// ===== core/dual_port_block_ram.sv
// top: configurable two-port block memory with fifo, rom and shift modes
//
// Design decisions made here: the address map.
`timescale 1ns/1ps

module dual_port_block_ram #(
	parameter int                     ROWS           = ram_block_pkg::ROWS,
	parameter int                     ROW_BITS       = ram_block_pkg::ROW_BITS,
	parameter int                     LINKS_PER_SIDE = ram_block_pkg::DIRECT_LINKS,
	parameter logic [ROWS*ROW_BITS-1:0] INIT_IMAGE   = '0
) (
	input  wire logic                    clk,
	input  wire logic                    srst,
	input  wire ram_block_pkg::cfg_t     cfg,
	input  wire ram_block_pkg::port_in_t a_in,
	input  wire ram_block_pkg::port_in_t b_in,
	output logic [35:0]                  a_rdata_q,
	output logic [35:0]                  b_rdata_q,
	output logic [35:0]                  tap_q,
	output logic                         fifo_full_q,
	output logic                         fifo_empty_q,
	output logic                         cfg_err_q
);

	// geometry is fixed: 128 rows of 36 bits
	if (ROWS * ROW_BITS != ram_block_pkg::TOTAL_BITS ||
		ROW_BITS != ram_block_pkg::DATA_W || ROWS != 128) begin : g_geom_bad
		$error("dual_port_block_ram: geometry must be 128 rows of 36 bits");
	end
	if (LINKS_PER_SIDE < 1 || LINKS_PER_SIDE > ram_block_pkg::DIRECT_LINKS) begin : g_link_bad
		$error("dual_port_block_ram: direct link count out of range");
	end

	ram_block_pkg::port_in_t pin [2];
	ram_block_pkg::width_t   pw [2];
	ram_block_pkg::mem_req_t req [2];
	logic [35:0]             rdata [2];
	logic [35:0]             rdata_q [2];
	logic                    eff_gate [2];
	logic                    out_gate [2];
	logic                    rd_issue [2];
	logic [5:0]              rd_off [2];
	logic                    cfg_bad;
	logic [8:0]              tap_bits;
	logic [16:0]             shift_bits;
	logic [35:0]             tap_mask;

	// fifo state
	logic [11:0] wptr_q;
	logic [11:0] rptr_q;
	logic [12:0] count_q;
	logic [12:0] count_d;
	logic [12:0] fifo_depth;
	logic        push;
	logic        pop;

	// shift state
	logic [6:0]  sh_ptr_q;
	logic        sh_v1_q;
	logic [6:0]  sh_row1_q;
	logic [35:0] sh_din1_q;
	logic        sh_step;

	assign pin[0] = a_in;
	assign pin[1] = b_in;
	assign pw[0]  = cfg.width_a;
	// fifo and shift modes run both ports at the port a width
	assign pw[1]  = (cfg.mode == ram_block_pkg::MODE_FIFO ||
		cfg.mode == ram_block_pkg::MODE_SHIFT) ? cfg.width_a : cfg.width_b;

	// gate selection for input and output registers
	assign eff_gate[0] = cfg.in_cross[0] ? b_in.gate : a_in.gate;
	assign eff_gate[1] = cfg.in_cross[1] ? a_in.gate : b_in.gate;
	assign out_gate[0] = cfg.out_cross[0] ? b_in.gate : a_in.gate;
	assign out_gate[1] = cfg.out_cross[1] ? a_in.gate : b_in.gate;

	// word address to row and bit offset
	function automatic logic [6:0] row_of(input logic [11:0] addr,
		input ram_block_pkg::width_t w);
		logic [11:0] r;
		r      = addr >> ram_block_pkg::lane_shift(w);
		row_of = r[6:0];
	endfunction

	function automatic logic [5:0] off_of(input logic [11:0] addr,
		input ram_block_pkg::width_t w);
		logic [11:0] lane;
		logic [17:0] prod;
		lane   = addr & ((12'h001 << ram_block_pkg::lane_shift(w)) - 12'h001);
		prod   = lane * ram_block_pkg::width_bits(w);
		off_of = prod[5:0];
	endfunction

	function automatic logic [35:0] field_mask(input ram_block_pkg::width_t w);
		field_mask = (36'h0_0000_0001 << ram_block_pkg::width_bits(w)) - 36'h0_0000_0001;
	endfunction

	// byte lanes of 9 bits for parity widths, 8 bits otherwise
	function automatic logic [35:0] byte_mask(input ram_block_pkg::width_t w,
		input logic [3:0] bmask);
		int unit;
		int idx;
		unit = ram_block_pkg::is_parity(w) ? 9 : 8;
		byte_mask = 36'hF_FFFF_FFFF;
		if (ram_block_pkg::has_bytes(w)) begin
			for (int i = 0; i < 36; i++) begin
				idx = i / unit;
				byte_mask[i] = (idx < 4) ? bmask[idx] : 1'b0;
			end
		end
	endfunction

	function automatic logic [35:0] write_mask(input logic [11:0] addr,
		input ram_block_pkg::width_t w, input logic [3:0] bmask);
		write_mask = (field_mask(w) & byte_mask(w, bmask)) << off_of(addr, w);
	endfunction

	// request from a plain read/write port
	function automatic ram_block_pkg::mem_req_t rw_req(input ram_block_pkg::port_in_t pi,
		input logic gate, input ram_block_pkg::width_t w, input logic wr_ok,
		input logic rd_ok);
		rw_req.en    = gate && (pi.we ? wr_ok : rd_ok);
		rw_req.row   = row_of(pi.addr, w);
		rw_req.bwe   = (pi.we && wr_ok) ? write_mask(pi.addr, w, pi.bmask) : '0;
		rw_req.wdata = (pi.wdata & field_mask(w)) << off_of(pi.addr, w);
	endfunction

	// configuration legality
	assign tap_bits   = 9'(cfg.tap_count) * 9'(ram_block_pkg::width_bits(cfg.width_a));
	assign shift_bits = 17'(tap_bits) * 17'(cfg.tap_len);
	assign tap_mask   = (tap_bits >= 9'(ram_block_pkg::DATA_W)) ? 36'hF_FFFF_FFFF :
		((36'h0_0000_0001 << tap_bits) - 36'h0_0000_0001);

	always_comb begin
		cfg_bad = 1'b0;
		if ((cfg.mode == ram_block_pkg::MODE_TDP || cfg.mode == ram_block_pkg::MODE_SDP) &&
			ram_block_pkg::is_parity(cfg.width_a) != ram_block_pkg::is_parity(cfg.width_b)) begin
			cfg_bad = 1'b1;
		end
		if (cfg.mode == ram_block_pkg::MODE_TDP &&
			(ram_block_pkg::width_bits(cfg.width_a) > ram_block_pkg::TDP_MAX_BITS ||
			ram_block_pkg::width_bits(cfg.width_b) > ram_block_pkg::TDP_MAX_BITS)) begin
			cfg_bad = 1'b1;
		end
		if (cfg.mode == ram_block_pkg::MODE_SHIFT) begin
			if (cfg.tap_count == 3'h0 || cfg.tap_len < 8'(ram_block_pkg::MIN_TAP_LEN) ||
				cfg.tap_len > 8'(ROWS)) begin
				cfg_bad = 1'b1;
			end
			if (tap_bits > 9'(ram_block_pkg::DATA_W)) begin
				cfg_bad = 1'b1;
			end
			if (shift_bits > 17'(ram_block_pkg::TOTAL_BITS)) begin
				cfg_bad = 1'b1;
			end
		end
		if (cfg.mode > ram_block_pkg::MODE_SHIFT || cfg.width_a > ram_block_pkg::W36 ||
			cfg.width_b > ram_block_pkg::W36) begin
			cfg_bad = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			cfg_err_q <= 1'b0;
		end else begin
			cfg_err_q <= cfg_bad;
		end
	end

	// fifo push and pop
	assign fifo_depth = 13'(ROWS) << ram_block_pkg::lane_shift(cfg.width_a);
	assign push = (cfg.mode == ram_block_pkg::MODE_FIFO) && !cfg_bad && eff_gate[0] &&
		a_in.we && !fifo_full_q;
	assign pop  = (cfg.mode == ram_block_pkg::MODE_FIFO) && !cfg_bad && eff_gate[1] &&
		!b_in.we && !fifo_empty_q;
	assign sh_step = (cfg.mode == ram_block_pkg::MODE_SHIFT) && !cfg_bad && eff_gate[0];

	always_comb begin
		case ({push, pop})
			2'b10:   count_d = count_q + 13'h0001;
			2'b01:   count_d = count_q - 13'h0001;
			default: count_d = count_q;
		endcase
	end

	// array requests per mode
	always_comb begin
		for (int p = 0; p < 2; p++) begin
			req[p]      = '0;
			rd_issue[p] = 1'b0;
			rd_off[p]   = off_of(pin[p].addr, pw[p]);
		end
		if (!cfg_bad) begin
			case (cfg.mode)
				ram_block_pkg::MODE_TDP: begin
					for (int p = 0; p < 2; p++) begin
						req[p]      = rw_req(pin[p], eff_gate[p], pw[p], 1'b1, 1'b1);
						rd_issue[p] = eff_gate[p] && !pin[p].we;
					end
				end
				ram_block_pkg::MODE_SDP: begin
					req[0]      = rw_req(pin[0], eff_gate[0], pw[0], 1'b1, 1'b0);
					req[1]      = rw_req(pin[1], eff_gate[1], pw[1], 1'b0, 1'b1);
					rd_issue[1] = eff_gate[1] && !pin[1].we;
				end
				ram_block_pkg::MODE_SP: begin
					req[0]      = rw_req(pin[0], eff_gate[0], pw[0], 1'b1, 1'b1);
					rd_issue[0] = eff_gate[0] && !pin[0].we;
				end
				ram_block_pkg::MODE_ROM: begin
					for (int p = 0; p < 2; p++) begin
						req[p]      = rw_req(pin[p], eff_gate[p], pw[p], 1'b0, 1'b1);
						rd_issue[p] = eff_gate[p] && !pin[p].we;
					end
				end
				ram_block_pkg::MODE_FIFO: begin
					req[0].en    = push;
					req[0].row   = row_of(wptr_q, pw[0]);
					req[0].bwe   = push ? write_mask(wptr_q, pw[0], 4'hF) : '0;
					req[0].wdata = (a_in.wdata & field_mask(pw[0])) << off_of(wptr_q, pw[0]);
					req[1].en    = pop;
					req[1].row   = row_of(rptr_q, pw[1]);
					rd_issue[1]  = pop;
					rd_off[1]    = off_of(rptr_q, pw[1]);
				end
				ram_block_pkg::MODE_SHIFT: begin
					// read row now, write it back shifted one cycle later
					req[1].en    = sh_step;
					req[1].row   = sh_ptr_q;
					req[0].en    = sh_v1_q;
					req[0].row   = sh_row1_q;
					req[0].bwe   = sh_v1_q ? tap_mask : '0;
					req[0].wdata = ((rdata[1] << ram_block_pkg::width_bits(cfg.width_a)) |
						sh_din1_q) & tap_mask;
				end
				default: begin
					req[0] = '0;
				end
			endcase
		end
	end

	ram_array #(
		.ROWS       (ROWS),
		.WIDTH      (ROW_BITS),
		.INIT_IMAGE (INIT_IMAGE)
	) u_array (
		.clk       (clk),
		.a_en      (req[0].en),
		.a_row     (req[0].row),
		.a_bwe     (req[0].bwe),
		.a_wdata   (req[0].wdata),
		.a_rdata_q (rdata[0]),
		.b_en      (req[1].en),
		.b_row     (req[1].row),
		.b_bwe     (req[1].bwe),
		.b_wdata   (req[1].wdata),
		.b_rdata_q (rdata[1])
	);

	// fifo pointers and flags
	always_ff @(posedge clk) begin
		if (srst || cfg.mode != ram_block_pkg::MODE_FIFO) begin
			wptr_q       <= ram_block_pkg::PTR_RST;
			rptr_q       <= ram_block_pkg::PTR_RST;
			count_q      <= ram_block_pkg::COUNT_RST;
			fifo_full_q  <= 1'b0;
			fifo_empty_q <= 1'b1;
		end else begin
			if (push) begin
				wptr_q <= (13'(wptr_q) == fifo_depth - 13'h0001) ? ram_block_pkg::PTR_RST :
					wptr_q + 12'h001;
			end
			if (pop) begin
				rptr_q <= (13'(rptr_q) == fifo_depth - 13'h0001) ? ram_block_pkg::PTR_RST :
					rptr_q + 12'h001;
			end
			count_q      <= count_d;
			fifo_full_q  <= (count_d == fifo_depth);
			fifo_empty_q <= (count_d == ram_block_pkg::COUNT_RST);
		end
	end

	// shift register walk
	always_ff @(posedge clk) begin
		if (srst || cfg.mode != ram_block_pkg::MODE_SHIFT) begin
			sh_ptr_q  <= ram_block_pkg::ROW_RST;
			sh_v1_q   <= 1'b0;
			sh_row1_q <= ram_block_pkg::ROW_RST;
			sh_din1_q <= ram_block_pkg::RDATA_RST;
		end else begin
			sh_v1_q   <= sh_step;
			sh_row1_q <= sh_ptr_q;
			sh_din1_q <= a_in.wdata & field_mask(cfg.width_a);
			if (sh_step) begin
				sh_ptr_q <= (8'(sh_ptr_q) == cfg.tap_len - 8'h01) ? ram_block_pkg::ROW_RST :
					sh_ptr_q + 7'h01;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst || a_in.clr) begin
			tap_q <= ram_block_pkg::RDATA_RST;
		end else if (sh_v1_q) begin
			tap_q <= rdata[1] & tap_mask;
		end
	end

	// read data path of each port
	for (genvar p = 0; p < 2; p++) begin : g_port
		logic                   s1_valid_q;
		logic [5:0]             s1_off_q;
		ram_block_pkg::width_t  s1_w_q;
		logic [35:0]            stage_q;
		logic [35:0]            lane;

		assign lane = (rdata[p] >> s1_off_q) & field_mask(s1_w_q);

		// address side is always registered
		always_ff @(posedge clk) begin
			if (srst) begin
				s1_valid_q <= 1'b0;
				s1_off_q   <= 6'h00;
				s1_w_q     <= ram_block_pkg::W1;
			end else begin
				s1_valid_q <= rd_issue[p];
				s1_off_q   <= rd_off[p];
				s1_w_q     <= pw[p];
			end
		end

		always_ff @(posedge clk) begin
			if (srst || pin[p].clr) begin
				stage_q <= ram_block_pkg::RDATA_RST;
			end else if (s1_valid_q) begin
				stage_q <= lane;
			end
		end

		always_ff @(posedge clk) begin
			if (srst || pin[p].clr) begin
				rdata_q[p] <= ram_block_pkg::RDATA_RST;
			end else if (!cfg.out_reg[p] && s1_valid_q) begin
				rdata_q[p] <= lane;
			end else if (cfg.out_reg[p] && out_gate[p]) begin
				rdata_q[p] <= stage_q;
			end
		end
	end

	assign a_rdata_q = rdata_q[0];
	assign b_rdata_q = rdata_q[1];

endmodule

// ===== tb/dual_port_block_ram_props.sv
// checker: port-level properties of the two-port block memory
`timescale 1ns/1ps
module dual_port_block_ram_props (
	input wire logic                    clk,
	input wire logic                    srst,
	input wire ram_block_pkg::cfg_t     cfg,
	input wire ram_block_pkg::port_in_t a_in,
	input wire ram_block_pkg::port_in_t b_in,
	input wire logic [35:0]             a_rdata_q,
	input wire logic [35:0]             b_rdata_q,
	input wire logic [35:0]             tap_q,
	input wire logic                    fifo_full_q,
	input wire logic                    fifo_empty_q,
	input wire logic                    cfg_err_q
);
	logic plain16;
	logic quiet_b;

	assign plain16 = cfg.mode == ram_block_pkg::MODE_TDP && cfg.width_a == ram_block_pkg::W16
		&& cfg.width_b == ram_block_pkg::W16 && cfg.in_cross == 2'b00
		&& cfg.out_reg == 2'b00 && cfg.out_cross == 2'b00;
	assign quiet_b = !b_in.clr && !(b_in.gate && b_in.we);

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	sequence s_wr_full;
		plain16 && quiet_b && a_in.gate && a_in.we && !a_in.clr && a_in.bmask[1:0] == 2'b11;
	endsequence
	sequence s_wr_mask;
		plain16 && quiet_b && a_in.gate && a_in.we && !a_in.clr && a_in.addr == $past(a_in.addr);
	endsequence
	sequence s_rd_b;
		plain16 && b_in.gate && !b_in.we && !b_in.clr && !(a_in.gate && a_in.we)
			&& b_in.addr == $past(a_in.addr);
	endsequence

	property p_wr_rd;
		s_wr_full ##1 s_rd_b ##1 !b_in.clr |-> ##1 b_rdata_q == {20'h00000, $past(a_in.wdata[15:0], 3)};
	endproperty
	property p_mask;
		s_wr_full ##1 s_wr_mask ##1 s_rd_b ##1 !b_in.clr |-> ##1 b_rdata_q[15:0] ==
			{($past(a_in.bmask[1], 3) ? $past(a_in.wdata[15:8], 3) : $past(a_in.wdata[15:8], 4)),
			($past(a_in.bmask[0], 3) ? $past(a_in.wdata[7:0], 3) : $past(a_in.wdata[7:0], 4))};
	endproperty
	property p_clr_a;
		a_in.clr |=> a_rdata_q == 36'h0_0000_0000 && tap_q == 36'h0_0000_0000;
	endproperty
	property p_clr_b;
		b_in.clr |=> b_rdata_q == 36'h0_0000_0000;
	endproperty
	property p_err_wide;
		cfg.mode == ram_block_pkg::MODE_TDP && (cfg.width_a inside {ram_block_pkg::W32,
			ram_block_pkg::W36} || cfg.width_b inside {ram_block_pkg::W32, ram_block_pkg::W36})
			|=> cfg_err_q;
	endproperty
	property p_err_mix;
		cfg.mode inside {ram_block_pkg::MODE_TDP, ram_block_pkg::MODE_SDP}
			&& ram_block_pkg::is_parity(cfg.width_a) != ram_block_pkg::is_parity(cfg.width_b)
			|=> cfg_err_q;
	endproperty
	property p_legal;
		plain16 |=> !cfg_err_q;
	endproperty
	property p_fifo_idle;
		cfg.mode != ram_block_pkg::MODE_FIFO ##1 cfg.mode != ram_block_pkg::MODE_FIFO
			|-> !fifo_full_q && fifo_empty_q;
	endproperty

	a_wr_rd: assert property (p_wr_rd) else $error("read after write gave wrong word");
	a_mask: assert property (p_mask) else $error("masked write merged wrongly");
	a_clr_a: assert property (p_clr_a) else $error("port a clear left data");
	a_clr_b: assert property (p_clr_b) else $error("port b clear left data");
	a_err_wide: assert property (p_err_wide) else $error("wide two-port setup accepted");
	a_err_mix: assert property (p_err_mix) else $error("mixed width families accepted");
	a_legal: assert property (p_legal) else $error("legal setup flagged");
	a_fifo_idle: assert property (p_fifo_idle) else $error("fifo flags active outside fifo");
endmodule

bind dual_port_block_ram dual_port_block_ram_props u_props (
	.clk          (clk),
	.srst         (srst),
	.cfg          (cfg),
	.a_in         (a_in),
	.b_in         (b_in),
	.a_rdata_q    (a_rdata_q),
	.b_rdata_q    (b_rdata_q),
	.tap_q        (tap_q),
	.fifo_full_q  (fifo_full_q),
	.fifo_empty_q (fifo_empty_q),
	.cfg_err_q    (cfg_err_q)
);

// ===== tb/user_port_model.sv
// partner: user logic driving both memory ports
`timescale 1ns/1ps
module user_port_model (
	input  wire logic              clk,
	output ram_block_pkg::port_in_t a_in,
	output ram_block_pkg::port_in_t b_in
);
	initial begin
		a_in = '0;
		b_in = '0;
	end

	// idle ports show a changing pattern, not the last request
	function automatic ram_block_pkg::port_in_t settle(input ram_block_pkg::port_in_t req,
		input ram_block_pkg::port_in_t prev);
		settle = req;
		if (!req.gate && !req.clr) begin
			settle = '0;
			settle.addr = ~prev.addr;
			settle.wdata = ~prev.wdata;
			settle.bmask = ~prev.bmask;
		end
	endfunction

	task automatic step(input ram_block_pkg::port_in_t a, input ram_block_pkg::port_in_t b);
		@(posedge clk);
		a_in <= settle(a, a_in);
		b_in <= settle(b, b_in);
	endtask
endmodule

// ===== tb/dual_port_block_ram_tb.sv
// testbench: self-checking bench of the two-port block memory
`timescale 1ns/1ps
module dual_port_block_ram_tb;
	typedef struct {
		int          due;
		int          sel;
		logic [35:0] exp;
	} note_t;

	logic                    clk;
	logic                    srst;
	ram_block_pkg::cfg_t     cfg;
	ram_block_pkg::port_in_t a_in;
	ram_block_pkg::port_in_t b_in;
	logic [35:0]             a_rdata_q;
	logic [35:0]             b_rdata_q;
	logic [35:0]             tap_q;
	logic                    fifo_full_q;
	logic                    fifo_empty_q;
	logic                    cfg_err_q;
	int                      failures = 0;
	int                      compares = 0;
	int                      cyc = 0;
	int                      seed;
	note_t                   notes[$];
	logic [35:0]             wd1;
	logic [35:0]             wd2;
	logic [35:0]             e18;
	logic [35:0]             got;
	ram_block_pkg::cfg_t     tbl[9];
	logic [8:0]              err = 9'h007;
	string                   names[5] = '{"a_rdata_q", "b_rdata_q", "cfg_err_q", "tap_q",
		"fifo_flags"};
	ram_block_pkg::port_in_t nop = '0;
	ram_block_pkg::port_in_t clr_rq = '{1'b0, 1'b0, 1'b1, 12'h000, 36'h0_0000_0000, 4'h0};

	dual_port_block_ram #(.INIT_IMAGE(4608'h1234_5678)) DUT (
		.clk          (clk),
		.srst         (srst),
		.cfg          (cfg),
		.a_in         (a_in),
		.b_in         (b_in),
		.a_rdata_q    (a_rdata_q),
		.b_rdata_q    (b_rdata_q),
		.tap_q        (tap_q),
		.fifo_full_q  (fifo_full_q),
		.fifo_empty_q (fifo_empty_q),
		.cfg_err_q    (cfg_err_q)
	);

	user_port_model u_usr (
		.clk  (clk),
		.a_in (a_in),
		.b_in (b_in)
	);

	initial clk = 1'b0;
	always #4 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;

	function automatic ram_block_pkg::port_in_t rq(input logic we, input logic [11:0] ad,
		input logic [35:0] wd, input logic [3:0] bm);
		rq = '{1'b1, we, 1'b0, ad, wd, bm};
	endfunction

	function automatic ram_block_pkg::cfg_t mk(input ram_block_pkg::mode_t m,
		input ram_block_pkg::width_t wa, input ram_block_pkg::width_t wb, input logic [1:0] oreg);
		mk = '{m, wa, wb, oreg, 2'h0, 2'h0, 8'h08, 3'h4};
	endfunction

	task automatic note(input int d, input int s, input logic [35:0] e);
		notes.push_back('{cyc + d, s, e});
	endtask

	task automatic set_cfg(input ram_block_pkg::cfg_t c);
		u_usr.step(nop, nop);
		cfg <= c;
	endtask

	task automatic pause(input int n);
		repeat (n) u_usr.step(nop, nop);
	endtask

	task automatic rnd(output logic [35:0] v);
		logic [63:0] t;
		t = {$random(seed), $random(seed)};
		v = t[35:0];
	endtask

	task automatic final_report;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// takes each expected result off the queue when it falls due
	always @(posedge clk) begin : monitor
		note_t n;
		#1;
		while (notes.size() > 0 && notes[0].due <= cyc) begin
			n = notes.pop_front();
			case (n.sel)
				0:       got = a_rdata_q;
				1:       got = b_rdata_q;
				2:       got = {35'h0_0000_0000, cfg_err_q};
				3:       got = tap_q;
				default: got = {34'h0_0000_0000, fifo_full_q, fifo_empty_q};
			endcase
			compares++;
			if (got !== n.exp) begin
				failures++;
				$display("mismatch %s expected %h seen %h", names[n.sel], n.exp, got);
			end
		end
	end

	initial begin
		repeat (3000) @(posedge clk);
		failures++;
		$display("watchdog expired");
		final_report;
	end

	initial begin
		cfg = mk(ram_block_pkg::MODE_TDP, ram_block_pkg::W16, ram_block_pkg::W16, 2'b00);
		srst = 1'b1;
		seed = 83947;
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		u_usr.step(rq(1'b0, 12'h000, 36'h0, 4'h0), rq(1'b0, 12'h001, 36'h0, 4'h0));
		note(3, 0, 36'h0_0000_5678);
		note(3, 1, 36'h0_0000_1234);
		pause(3);
		$display("test preset image done");
		for (int k = 0; k < 4; k++) begin
			rnd(wd1);
			rnd(wd2);
			u_usr.step(rq(1'b1, 12'h008 + 12'(k), wd1, 4'hF), nop);
			u_usr.step(rq(1'b1, 12'h008 + 12'(k), wd2, 4'(k)), nop);
			u_usr.step(nop, rq(1'b0, 12'h008 + 12'(k), 36'h0, 4'h0));
			note(3, 1, {20'h00000, k[1] ? wd2[15:8] : wd1[15:8], k[0] ? wd2[7:0] : wd1[7:0]});
		end
		pause(2);
		$display("test byte masks done");
		set_cfg(mk(ram_block_pkg::MODE_TDP, ram_block_pkg::W8, ram_block_pkg::W8, 2'b00));
		rnd(wd1);
		u_usr.step(rq(1'b1, 12'h040, wd1, 4'h0), nop);
		u_usr.step(nop, rq(1'b0, 12'h040, 36'h0, 4'h0));
		note(3, 1, {28'h000_0000, wd1[7:0]});
		pause(2);
		$display("test narrow write done");
		set_cfg(mk(ram_block_pkg::MODE_TDP, ram_block_pkg::W18, ram_block_pkg::W18, 2'b00));
		rnd(wd1);
		rnd(wd2);
		e18 = {18'h00000, wd1[17:9], wd2[8:0]};
		u_usr.step(rq(1'b1, 12'h020, wd1, 4'hF), nop);
		u_usr.step(rq(1'b1, 12'h020, wd2, 4'h1), nop);
		u_usr.step(nop, rq(1'b0, 12'h020, 36'h0, 4'h0));
		note(3, 1, e18);
		pause(2);
		$display("test parity lanes done");
		set_cfg(mk(ram_block_pkg::MODE_TDP, ram_block_pkg::W18, ram_block_pkg::W18, 2'b10));
		for (int j = 0; j < 2; j++) begin
			u_usr.step(clr_rq, clr_rq);
			note(2, 0, 36'h0);
			note(2, 1, 36'h0);
			u_usr.step(nop, rq(1'b0, 12'h020, 36'h0, 4'h0));
			note(3, 1, 36'h0);
			note(4, 1, e18);
			u_usr.step(nop, rq(1'b0, 12'h020, 36'h0, 4'h0));
			u_usr.step(nop, rq(1'b0, 12'h020, 36'h0, 4'h0));
			pause(2);
		end
		$display("test output register and clear done");
		tbl[0] = mk(ram_block_pkg::MODE_SHIFT, ram_block_pkg::W8, ram_block_pkg::W8, 2'b00);
		tbl[0].tap_len = 8'h02;
		set_cfg(tbl[0]);
		rnd(wd1);
		rnd(wd2);
		u_usr.step(rq(1'b1, 12'h000, wd1, 4'h0), nop);
		note(3, 3, 36'h0_1234_5678);
		u_usr.step(rq(1'b1, 12'h000, wd2, 4'h0), nop);
		note(3, 3, 36'h0_0000_0000);
		u_usr.step(rq(1'b1, 12'h000, wd1, 4'h0), nop);
		note(3, 3, {12'h034, 16'h5678, wd1[7:0]});
		u_usr.step(rq(1'b1, 12'h000, wd2, 4'h0), nop);
		note(3, 3, {28'h000_0000, wd2[7:0]});
		pause(2);
		$display("test shift register done");
		set_cfg(mk(ram_block_pkg::MODE_FIFO, ram_block_pkg::W8, ram_block_pkg::W8, 2'b00));
		rnd(wd1);
		u_usr.step(rq(1'b1, 12'h000, wd1, 4'h0), nop);
		note(2, 4, 36'h0_0000_0000);
		u_usr.step(nop, rq(1'b0, 12'h000, 36'h0, 4'h0));
		note(2, 4, 36'h0_0000_0001);
		note(3, 1, {28'h000_0000, wd1[7:0]});
		pause(2);
		$display("test fifo done");
		tbl = '{mk(ram_block_pkg::MODE_TDP, ram_block_pkg::W36, ram_block_pkg::W36, 2'b00),
			mk(ram_block_pkg::MODE_TDP, ram_block_pkg::W16, ram_block_pkg::W18, 2'b00),
			mk(ram_block_pkg::MODE_SDP, ram_block_pkg::W8, ram_block_pkg::W9, 2'b00),
			mk(ram_block_pkg::MODE_SDP, ram_block_pkg::W32, ram_block_pkg::W1, 2'b00),
			mk(ram_block_pkg::MODE_SP, ram_block_pkg::W36, ram_block_pkg::W36, 2'b00),
			mk(ram_block_pkg::MODE_FIFO, ram_block_pkg::W8, ram_block_pkg::W8, 2'b00),
			mk(ram_block_pkg::MODE_ROM, ram_block_pkg::W36, ram_block_pkg::W36, 2'b00),
			mk(ram_block_pkg::MODE_SHIFT, ram_block_pkg::W8, ram_block_pkg::W8, 2'b00),
			mk(ram_block_pkg::MODE_TDP, ram_block_pkg::W18, ram_block_pkg::W9, 2'b00)};
		foreach (tbl[i]) begin
			set_cfg(tbl[i]);
			note(2, 2, {35'h0_0000_0000, err[i]});
		end
		pause(4);
		$display("test configuration checks done");
		final_report;
	end
endmodule
